// [pkg/rpm_core_cfg.svh]
//
// Purpose: named constants for the reset and power sequencer
// Assumes: included by the design files by bare name
// Notes: offsets, bit positions, counts and opcodes only
//
`ifndef RPM_CORE_CFG_SVH
`define RPM_CORE_CFG_SVH

// power control bit positions
`define RPM_PC_IDLE_BIT 0
`define RPM_PC_PDOWN_BIT 1

// reset qualification
`define RPM_RESET_MC 8'h02
`define RPM_OSC_PER_MC 8'h0C
`define RPM_PHASE_TICK 1'b1

// serial entry pattern length
`define RPM_ENTRY_BITS 10

// fixed program locations
`define RPM_VEC_RESET 11'h000
`define RPM_VEC_BASE 11'h003
`define RPM_VEC_SHIFT 3
`define RPM_CODE_BYTES 2048

// data space layout
`define RPM_RAM_TOP 8'h3F
`define RPM_SFR_BASE 8'h80

// opcodes with no effect on this part
`define RPM_OP_LONG_JUMP 8'h02
`define RPM_OP_LONG_CALL 8'h12
`define RPM_OP_XMOVE_RD_DP 8'hE0
`define RPM_OP_XMOVE_RD_R0 8'hE2
`define RPM_OP_XMOVE_RD_R1 8'hE3
`define RPM_OP_XMOVE_WR_DP 8'hF0
`define RPM_OP_XMOVE_WR_R0 8'hF2
`define RPM_OP_XMOVE_WR_R1 8'hF3

`endif

// [pkg/rpm_core_pkg.sv]
//
// Purpose: types shared by the reset and power sequencer
// Assumes: nothing
// Notes: widths follow the constants header
//
package rpm_core_pkg;

  // power mode of the core
  typedef enum logic [1:0] {
    RPM_RUN,
    RPM_IDLE,
    RPM_PDOWN
  } rpm_mode_t;

  // which blocks keep their clock
  typedef struct packed {
    logic cpu;
    logic timer0;
    logic i2c;
    logic irq;
    logic adc;
    logic pwm_cnt;
    logic osc;
  } rpm_run_en_t;

  // result of a data space and opcode lookup
  typedef struct packed {
    logic ram_sel;
    logic ram_void;
    logic sfr_sel;
    logic bit_ok;
    logic op_void;
  } rpm_decode_t;

  // port latch images
  typedef struct packed {
    logic [4:0] p0;
    logic [7:0] p1;
    logic [7:0] p3;
  } rpm_ports_t;

endpackage : rpm_core_pkg

// [hw/rpm_mem_decode.sv]
//
// Purpose: data space, bit address and opcode lookup
// Assumes: combinational, used by rpm_core_ctl
// Notes: the mask picks which SFR rows are bit addressable
//
`timescale 1ns/1ps
`include "rpm_core_cfg.svh"

module rpm_mem_decode #(
  parameter logic [15:0] BIT_ROW_MASK = 16'h01FF
) (
  // lookup request
  input wire logic [7:0] addr,
  input wire logic direct,
  input wire logic [7:0] opcode,
  // lookup result
  output rpm_core_pkg::rpm_decode_t dec
);
  import rpm_core_pkg::*;

  // ****************************************
  // space selection
  // ****************************************
  wire upper_half = (addr >= `RPM_SFR_BASE);
  wire row_start = (addr[2:0] == 3'h0);
  wire [3:0] row = addr[6:3];
  wire ext_move = (opcode == `RPM_OP_XMOVE_RD_DP) || (opcode == `RPM_OP_XMOVE_RD_R0) ||
                  (opcode == `RPM_OP_XMOVE_RD_R1) || (opcode == `RPM_OP_XMOVE_WR_DP) ||
                  (opcode == `RPM_OP_XMOVE_WR_R0) || (opcode == `RPM_OP_XMOVE_WR_R1);

  // lower half holds 64 real bytes, upper half is SFR only by direct access
  assign dec.ram_sel = !upper_half && (addr <= `RPM_RAM_TOP);
  assign dec.ram_void = !upper_half && (addr > `RPM_RAM_TOP);
  assign dec.sfr_sel = upper_half && direct;
  assign dec.bit_ok = upper_half && direct && row_start && BIT_ROW_MASK[row];
  assign dec.op_void = ext_move || (opcode == `RPM_OP_LONG_JUMP) ||
                       (opcode == `RPM_OP_LONG_CALL);

endmodule : rpm_mem_decode

// [hw/rpm_core_ctl.sv]
//
// Purpose: reset qualification, programming entry, idle and power-down control
// Assumes: sys_clk is the oscillator input, all inputs synchronous to it
// Notes: the core itself sits outside; this block steers its clocks and vectors
//
`timescale 1ns/1ps
`include "rpm_core_cfg.svh"

// Summary of operation
// - reset pin high two machine cycles resets
// - ten-bit LSB-first pattern enters programming state
// - oscillator input divided by two first
// - idle stops cpu, adc, pwm; others run
// - idle starts after requesting instruction completes
// - idle keeps cpu, ram and SFR values
// - enabled interrupt ends idle at its vector
// - reset during idle acts as power-on
// - power-down stops oscillator, keeps ram and pointer pair
// - only reset ends power-down
// - mode requests come from power control bits
// - pins keep latched data, pwm pin apart
// - external move and long ops do nothing
// - fixed reset and interrupt vector addresses
// - program space is 2048 internal bytes
// - 128-byte data space, 64 bytes present
// - SFRs at 80H-FFH, direct access only
// - no external memory or strobes
// - pointer pair forms 16-bit code offset
// - nine of twenty-one SFRs bit addressable
module rpm_core_ctl #(
  parameter logic [7:0] OSC_PER_MC = `RPM_OSC_PER_MC,
  parameter logic [`RPM_ENTRY_BITS-1:0] ENTRY_CODE = 10'h2A5,
  parameter logic [15:0] BIT_ROW_MASK = 16'h01FF
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // reset pin from the outside
  input wire logic rst_pin,
  // core handshake
  input wire logic instr_done,
  input wire logic power_control_wr,
  input wire logic [7:0] power_control_wdata,
  input wire logic irq_req,
  input wire logic [2:0] irq_src,
  input wire logic [7:0] opcode,
  input wire logic [7:0] data_addr,
  input wire logic data_direct,
  input wire logic [10:0] code_base,
  input wire logic [7:0] acc,
  // pointer pair writes
  input wire logic pointer_high_wr,
  input wire logic pointer_low_wr,
  input wire logic [7:0] pointer_wdata,
  // port latches and pwm
  input wire rpm_core_pkg::rpm_ports_t port_latch,
  input wire logic pwm_en,
  input wire logic pwm_level,
  // control out
  output logic core_reset,
  output logic prog_mode,
  output logic div_phase,
  output rpm_core_pkg::rpm_mode_t mode,
  output rpm_core_pkg::rpm_run_en_t run_en,
  output logic pc_load,
  output logic [10:0] pc_load_addr,
  output logic [15:0] data_pointer_pair,
  output logic [10:0] code_table_addr,
  output rpm_core_pkg::rpm_decode_t dec,
  output logic ext_strobe_n,
  // pins
  output rpm_core_pkg::rpm_ports_t port_out,
  output logic pwm_pin
);
  import rpm_core_pkg::*;

  // ****************************************
  // divide-by-two and reset qualification
  // ****************************************
  logic div_phase_q;
  logic [7:0] high_cnt_q;
  logic [7:0] high_cnt_d;
  logic core_reset_q;
  logic core_reset_d;
  wire [7:0] reset_len = 8'(`RPM_RESET_MC * OSC_PER_MC);
  wire reset_hit = rst_pin && (high_cnt_q == reset_len - 8'h01);
  wire phase_tick = (div_phase_q == `RPM_PHASE_TICK);

  // count oscillator edges with the pin high, saturating at the limit
  assign high_cnt_d = !rst_pin ? 8'h00 : (reset_hit ? high_cnt_q : high_cnt_q + 8'h01);
  // set on a qualified pin, clear only on a divided-clock tick with the pin low
  assign core_reset_d = reset_hit ? 1'b1 : ((!rst_pin && phase_tick) ? 1'b0 : core_reset_q);

  // flip-flops for the divider and reset
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      div_phase_q <= 1'b0;
      high_cnt_q <= 8'h00;
      core_reset_q <= 1'b1;
    end
    else
    begin
      div_phase_q <= !div_phase_q;
      high_cnt_q <= high_cnt_d;
      core_reset_q <= core_reset_d;
    end
  end

  // ****************************************
  // serial entry into the programming state
  // ****************************************
  logic [`RPM_ENTRY_BITS-1:0] entry_sr_q;
  logic [3:0] entry_cnt_q;
  logic prog_mode_q;
  wire reset_fall = core_reset_q && !core_reset_d;
  wire entry_full = (entry_cnt_q == 4'(`RPM_ENTRY_BITS));
  wire entry_match = entry_full && (entry_sr_q == ENTRY_CODE);

  // each oscillator edge strobes one bit, first bit lands at the bottom
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      entry_sr_q <= '0;
      entry_cnt_q <= 4'h0;
      prog_mode_q <= 1'b0;
    end
    else if (reset_fall)
    begin
      entry_sr_q <= '0;
      entry_cnt_q <= 4'h0;
    end
    else
    begin
      if (!entry_full && !core_reset_q)
      begin
        entry_sr_q <= {rst_pin, entry_sr_q[`RPM_ENTRY_BITS-1:1]};
        entry_cnt_q <= entry_cnt_q + 4'h1;
      end
      if (entry_match)
        prog_mode_q <= 1'b1;
    end
  end

  // ****************************************
  // power mode sequencing
  // ****************************************
  rpm_mode_t mode_q;
  rpm_mode_t mode_d;
  logic idle_pend_q;
  logic pd_pend_q;
  wire req_idle = power_control_wr && power_control_wdata[`RPM_PC_IDLE_BIT];
  wire req_pd = power_control_wr && power_control_wdata[`RPM_PC_PDOWN_BIT];

  // next mode; power-down wins over idle when both are asked
  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      RPM_RUN:
      begin
        if (instr_done && pd_pend_q)
          mode_d = RPM_PDOWN;
        else if (instr_done && idle_pend_q)
          mode_d = RPM_IDLE;
      end
      RPM_IDLE:
      begin
        if (irq_req)
          mode_d = RPM_RUN;
      end
      RPM_PDOWN:
        mode_d = RPM_PDOWN;
      default:
        mode_d = RPM_RUN;
    endcase
    if (core_reset_q)
      mode_d = RPM_RUN;
  end

  // mode and pending requests
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      mode_q <= RPM_RUN;
      idle_pend_q <= 1'b0;
      pd_pend_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      idle_pend_q <= !core_reset_q && (req_idle || (idle_pend_q && !instr_done));
      pd_pend_q <= !core_reset_q && (req_pd || (pd_pend_q && !instr_done));
    end
  end

  // clock gating per mode
  rpm_run_en_t run_en_q;
  rpm_run_en_t run_en_d;
  assign run_en_d.cpu = (mode_d == RPM_RUN);
  assign run_en_d.timer0 = (mode_d != RPM_PDOWN);
  assign run_en_d.i2c = (mode_d != RPM_PDOWN);
  assign run_en_d.irq = (mode_d != RPM_PDOWN);
  assign run_en_d.adc = (mode_d == RPM_RUN);
  assign run_en_d.pwm_cnt = (mode_d == RPM_RUN);
  assign run_en_d.osc = (mode_d != RPM_PDOWN);

  // registered enables
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      run_en_q <= '{default: 1'b1};
    else
      run_en_q <= run_en_d;
  end

  // ****************************************
  // vectors
  // ****************************************
  logic pc_load_q;
  logic [10:0] pc_load_addr_q;
  wire irq_take = irq_req && (mode_q != RPM_PDOWN) && !core_reset_q;
  wire [10:0] irq_vec = `RPM_VEC_BASE + (11'(irq_src) << `RPM_VEC_SHIFT);

  // reset release loads 000, a taken interrupt loads its vector
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      pc_load_q <= 1'b0;
      pc_load_addr_q <= `RPM_VEC_RESET;
    end
    else
    begin
      pc_load_q <= reset_fall || irq_take;
      if (reset_fall)
        pc_load_addr_q <= `RPM_VEC_RESET;
      else if (irq_take)
        pc_load_addr_q <= irq_vec;
    end
  end

  // ****************************************
  // pointer pair and code table address
  // ****************************************
  logic [7:0] ptr_hi_q;
  logic [7:0] ptr_lo_q;
  logic [10:0] code_table_addr_q;
  wire ptr_wr_ok = (mode_q == RPM_RUN) && !core_reset_q;
  wire [15:0] table_sum = {ptr_hi_q, ptr_lo_q} + {8'h00, acc};

  // bytes are written one at a time, read together as a table offset
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      ptr_hi_q <= 8'h00;
      ptr_lo_q <= 8'h00;
      code_table_addr_q <= 11'h000;
    end
    else
    begin
      if (ptr_wr_ok && pointer_high_wr)
        ptr_hi_q <= pointer_wdata;
      if (ptr_wr_ok && pointer_low_wr)
        ptr_lo_q <= pointer_wdata;
      code_table_addr_q <= table_sum[10:0];
    end
  end

  // ****************************************
  // pins and memory decode
  // ****************************************
  rpm_ports_t port_q;
  logic pwm_pin_q;
  wire low_power = (mode_q != RPM_RUN);

  // latched data always reaches the pins, pwm pin high while asleep
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      port_q <= '{default: '1};
      pwm_pin_q <= 1'b1;
    end
    else
    begin
      port_q <= port_latch;
      pwm_pin_q <= low_power ? 1'b1 : (pwm_en ? pwm_level : port_latch.p0[4]);
    end
  end

  rpm_mem_decode #(
    .BIT_ROW_MASK(BIT_ROW_MASK)
  ) u_decode (
    .addr(data_addr),
    .direct(data_direct),
    .opcode(opcode),
    .dec(dec)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign core_reset = core_reset_q;
  assign prog_mode = prog_mode_q;
  assign div_phase = div_phase_q;
  assign mode = mode_q;
  assign run_en = run_en_q;
  assign pc_load = pc_load_q;
  assign pc_load_addr = pc_load_addr_q;
  assign data_pointer_pair = {ptr_hi_q, ptr_lo_q};
  assign code_table_addr = code_table_addr_q;
  assign ext_strobe_n = 1'b1;
  assign port_out = port_q;
  assign pwm_pin = pwm_pin_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence idle_ask_s;
    (mode_q == RPM_RUN) && idle_pend_q && !pd_pend_q && instr_done && !core_reset_q;
  endsequence

  sequence idle_wake_s;
    (mode_q == RPM_IDLE) && irq_req && !core_reset_q;
  endsequence

  reset_qualify_a: assert property (reset_hit |=> core_reset_q)
    else $error("qualified reset pin did not reset");
  reset_length_a: assert property ($rose(core_reset_q) |-> $past(high_cnt_q) == reset_len - 8'h01)
    else $error("reset taken before two machine cycles");
  reset_release_a: assert property ($fell(core_reset_q) |-> $past(div_phase_q) && !$past(rst_pin))
    else $error("reset released off the divided clock");
  entry_match_a: assert property (entry_match |=> prog_mode_q)
    else $error("entry pattern did not enter programming");
  idle_entry_a: assert property (idle_ask_s |=> (mode_q == RPM_IDLE) && !run_en.cpu && run_en.timer0)
    else $error("idle not entered after instruction");
  idle_wake_a: assert property (idle_wake_s |=> pc_load_q && pc_load_addr_q == `RPM_VEC_BASE
                                + (11'($past(irq_src)) << `RPM_VEC_SHIFT) && mode_q == RPM_RUN)
    else $error("interrupt did not end idle at its vector");
  pdown_hold_a: assert property ((mode_q == RPM_PDOWN) && !core_reset_q |=> mode_q == RPM_PDOWN)
    else $error("power-down left without reset");
  pdown_osc_a: assert property ((mode_q == RPM_PDOWN) [*2] |-> !run_en.osc)
    else $error("oscillator runs in power-down");
  pointer_hold_a: assert property (low_power && !core_reset_q |=> $stable({ptr_hi_q, ptr_lo_q}))
    else $error("pointer changed while asleep");
  pwm_sleep_a: assert property (low_power |=> pwm_pin_q)
    else $error("pwm pin not high while asleep");
  reset_vector_a: assert property ($fell(core_reset_q) |-> pc_load_q && pc_load_addr_q == `RPM_VEC_RESET)
    else $error("reset release did not load vector 000");

endmodule : rpm_core_ctl

// [verification/rpm_prog_model.sv]
//
// Purpose: reset pin source and serial entry programmer
// Assumes: tasks are called from tb just after a clock edge
// Notes: the pin rests low, as its pull-down leaves it
//
`timescale 1ns/1ps
module rpm_prog_model (
  // clock and core state
  input wire logic sys_clk,
  input wire logic core_reset,
  input wire logic div_phase,
  // reset pin
  output logic rst_pin
);
  initial rst_pin = 1'b0;

  // hold the pin high for n sampled edges, then release it low
  task automatic hold_high(input int n);
    @(posedge sys_clk);
    rst_pin <= 1'b1;
    repeat (n) @(posedge sys_clk);
    rst_pin <= 1'b0;
  endtask : hold_high

  // shift a word lsb first, one bit per oscillator edge, from the release edge on
  task automatic send_entry(input logic [9:0] word);
    @(posedge sys_clk iff (core_reset === 1'b1 && div_phase === 1'b1));
    for (int i = 0; i < 10; i++)
    begin
      rst_pin <= word[i];
      @(posedge sys_clk);
    end
    rst_pin <= 1'b0;
  endtask : send_entry
endmodule : rpm_prog_model

// [verification/tb.sv]
//
// Purpose: self-checking bench for the reset and power sequencer
// Assumes: machine cycle shortened to 2 clocks
// Notes: vector loads are checked from a queue by a watcher
//
`timescale 1ns/1ps
module tb;
  import rpm_core_pkg::*;
  localparam logic [7:0] OSC = 8'h02;
  localparam logic [9:0] ENTRY = 10'h2a5;
  logic sys_clk = 1'b0, reset_n = 1'b0, instr_done = 1'b0, power_control_wr = 1'b0;
  logic irq_req = 1'b0, data_direct = 1'b0, pointer_high_wr = 1'b0, pointer_low_wr = 1'b0;
  logic pwm_en = 1'b0, pwm_level = 1'b0;
  logic [7:0] power_control_wdata = 8'h00, opcode = 8'h00, data_addr = 8'h00, acc = 8'h00, pointer_wdata = 8'h00;
  logic [2:0] irq_src = 3'h0;
  logic [10:0] code_base = 11'h000;
  rpm_ports_t port_latch = '1;
  wire logic rst_pin, core_reset, prog_mode, div_phase, pc_load, ext_strobe_n, pwm_pin;
  rpm_mode_t mode;
  rpm_run_en_t run_en;
  rpm_decode_t dec;
  rpm_ports_t port_out;
  logic [10:0] pc_load_addr, code_table_addr;
  logic [15:0] data_pointer_pair;
  int fail_count = 0, checked = 0;
  logic [10:0] exp_q[$];

  rpm_core_ctl #(.OSC_PER_MC(OSC), .ENTRY_CODE(ENTRY), .BIT_ROW_MASK(16'h01ff)) i_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .rst_pin(rst_pin), .instr_done(instr_done),
    .power_control_wr(power_control_wr), .power_control_wdata(power_control_wdata), .irq_req(irq_req),
    .irq_src(irq_src), .opcode(opcode), .data_addr(data_addr), .data_direct(data_direct),
    .code_base(code_base), .acc(acc), .pointer_high_wr(pointer_high_wr), .pointer_low_wr(pointer_low_wr),
    .pointer_wdata(pointer_wdata), .port_latch(port_latch), .pwm_en(pwm_en), .pwm_level(pwm_level),
    .core_reset(core_reset), .prog_mode(prog_mode), .div_phase(div_phase), .mode(mode), .run_en(run_en),
    .pc_load(pc_load), .pc_load_addr(pc_load_addr), .data_pointer_pair(data_pointer_pair),
    .code_table_addr(code_table_addr), .dec(dec), .ext_strobe_n(ext_strobe_n), .port_out(port_out),
    .pwm_pin(pwm_pin));
  rpm_prog_model i_prog (.sys_clk(sys_clk), .core_reset(core_reset), .div_phase(div_phase), .rst_pin(rst_pin));

  // ****************************************
  // clock, helpers and verdict
  // ****************************************
  initial forever #2 sys_clk = ~sys_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : step

  // one-cycle strobes, raised and dropped on rising edges
  task automatic pc_write(input logic [7:0] v);
    step(1);
    power_control_wr <= 1'b1;
    power_control_wdata <= v;
    step(1);
    power_control_wr <= 1'b0;
  endtask : pc_write

  task automatic idone;
    step(1);
    instr_done <= 1'b1;
    step(1);
    instr_done <= 1'b0;
  endtask : idone

  task automatic irq(input logic [2:0] s);
    step(1);
    irq_req <= 1'b1;
    irq_src <= s;
    step(1);
    irq_req <= 1'b0;
  endtask : irq

  // watcher: every vector load takes the oldest expected address
  initial forever
  begin
    @(posedge sys_clk);
    #1;
    if (pc_load === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(1, 0);
      else
        check(pc_load_addr, exp_q.pop_front());
    end
  end

  // watchdog against a hang
  initial
  begin
    repeat (4000) @(posedge sys_clk);
    fail_count++;
    close_out();
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial
  begin
    logic [15:0] ptr;
    logic [7:0] a;
    logic ph;
    void'($urandom(32'h59b3));
    // reset, release and a wrong entry word
    step(3);
    reset_n <= 1'b1;
    pwm_en <= 1'b1;
    pwm_level <= 1'($urandom);
    exp_q.push_back(11'h000);
    #1;
    check(core_reset, 1);
    check(run_en, 7'h7f);
    check(port_out, 21'h1f_ffff);
    i_prog.send_entry(ENTRY ^ 10'h200);
    step(2);
    #1;
    check(prog_mode, 0);
    check(pwm_pin, pwm_level);
    check(exp_q.size(), 0);
    check(ext_strobe_n, 1);
    for (int i = 0; i < 4; i++)
    begin
      ph = div_phase;
      step(1);
      #1;
      check(div_phase, !ph);
    end
    $display("test reset done");
    // interrupt sources 0 to 6 each load their own vector
    for (int s = 0; s < 7; s++)
    begin
      exp_q.push_back(11'h003 + 11'(8 * s));
      irq(3'(s));
    end
    step(2);
    #1;
    check(exp_q.size(), 0);
    $display("test vectors done");
    // pointer pair and code table offset
    ptr = 16'($urandom);
    a = 8'($urandom);
    step(1);
    pointer_high_wr <= 1'b1;
    pointer_wdata <= ptr[15:8];
    step(1);
    pointer_high_wr <= 1'b0;
    pointer_low_wr <= 1'b1;
    pointer_wdata <= ptr[7:0];
    acc <= a;
    step(1);
    pointer_low_wr <= 1'b0;
    step(2);
    #1;
    check(data_pointer_pair, ptr);
    check(code_table_addr, 11'(ptr + 16'(a)));
    $display("test pointer done");
    // idle waits for the instruction end, keeps state, ends on interrupt
    pc_write(8'h01);
    step(2);
    #1;
    check(mode, RPM_RUN);
    idone();
    step(1);
    #1;
    check(mode, RPM_IDLE);
    check(run_en, 7'h39);
    step(1);
    pointer_high_wr <= 1'b1;
    pointer_wdata <= ~ptr[15:8];
    port_latch <= 21'($urandom);
    step(1);
    pointer_high_wr <= 1'b0;
    step(2);
    #1;
    check(data_pointer_pair, ptr);
    check(port_out, port_latch);
    check(pwm_pin, 1);
    exp_q.push_back(11'h013);
    irq(3'd2);
    step(1);
    #1;
    check(mode, RPM_RUN);
    check(exp_q.size(), 0);
    $display("test idle done");
    // with the pwm function off the pin follows its port latch bit
    step(1);
    pwm_en <= 1'b0;
    step(2);
    #1;
    check(pwm_pin, port_latch.p0[4]);
    $display("test pwm pin done");
    // data space and opcode lookup over every value
    for (int i = 0; i < 256; i++)
    begin
      step(1);
      opcode <= 8'(i);
      data_addr <= 8'(i);
      data_direct <= ~i[0];
      #1;
      check(dec.op_void, 8'(i) inside {8'h02, 8'h12, 8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3});
      check(dec.ram_sel, i < 64);
      if (i < 128)
        check(dec.ram_void, i >= 64);
      check(dec.sfr_sel, i >= 128 && !i[0]);
      if (i >= 128 && !i[0])
        check(dec.bit_ok, i % 8 == 0 && i <= 192);
    end
    $display("test decode done");
    // power-down ignores interrupts, only a full-length pin reset ends it
    pc_write(8'h03);
    idone();
    step(1);
    #1;
    check(mode, RPM_PDOWN);
    check({run_en.osc, run_en.cpu}, 2'b00);
    irq(3'd0);
    step(2);
    #1;
    check(mode, RPM_PDOWN);
    check(pwm_pin, 1);
    check(port_out, port_latch);
    i_prog.hold_high(2 * OSC - 1);
    step(3);
    #1;
    check(core_reset, 0);
    exp_q.push_back(11'h000);
    i_prog.hold_high(2 * OSC);
    #1;
    check(core_reset, 1);
    i_prog.send_entry(ENTRY);
    step(2);
    #1;
    check(prog_mode, 1);
    check(mode, RPM_RUN);
    check(run_en, 7'h7f);
    check(exp_q.size(), 0);
    $display("test power-down done");
    close_out();
  end
endmodule : tb
